// File: src/adc_pkg.sv
// Constants shared by the device command and status core
`default_nettype none
package adc_pkg;
  localparam int DATA_W = 8;
  localparam int BCNT_W = 16;
  localparam int TAG_W = 5;
  localparam int QDEPTH = 32;
  // Register select codes on the host port
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ERROR = 3'h1;
  localparam logic [2:0] REG_SECCNT = 3'h2;
  localparam logic [2:0] REG_LBA_LO = 3'h3;
  localparam logic [2:0] REG_BCNT_LO = 3'h4;
  localparam logic [2:0] REG_BCNT_HI = 3'h5;
  localparam logic [2:0] REG_DEVICE = 3'h6;
  localparam logic [2:0] REG_COMMAND = 3'h7;
  // Status, error and device register bit positions and reset values
  localparam int ST_BUSY = 7;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABORT = 2;
  localparam int DEV_SEL_BIT = 4;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] ERROR_RST = 8'h01;
  // Signature values; arbitrary, chosen for this core
  localparam logic [7:0] SIG_PKT_LO = 8'h14;
  localparam logic [7:0] SIG_PKT_HI = 8'hEB;
  localparam logic [7:0] SIG_ATA_LO = 8'h00;
  localparam logic [7:0] SIG_ATA_HI = 8'h00;
  localparam logic [7:0] SIG_COUNT = 8'h01;
  localparam logic [7:0] SIG_LBA = 8'h01;
endpackage
`default_nettype wire

// File: src/adc_queue.sv
// Outstanding command tracker, one bit per tag
`default_nettype none
module adc_queue #(
  parameter int DEPTH = adc_pkg::QDEPTH,
  parameter int TW = adc_pkg::TAG_W
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_set,
  input wire logic [TW-1:0] i_set_tag,
  input wire logic i_clear,
  input wire logic [TW-1:0] i_clear_tag,
  output logic o_any,
  output logic o_busy_tag
);
  logic [DEPTH-1:0] pend_reg;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      // Set wins over a clear on the same tag
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          pend_reg[g] <= 1'b0;
        end else if (i_set && i_set_tag == TW'(g)) begin
          pend_reg[g] <= 1'b1;
        end else if (i_clear && i_clear_tag == TW'(g)) begin
          pend_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign o_any = |pend_reg;
  assign o_busy_tag = pend_reg[i_set_tag];
endmodule
`default_nettype wire

// File: src/adc_core.sv
// Device side command acceptance, completion and status core
`default_nettype none
// Overview of operation
// - Command accepted only when selected, not busy, and command register written
// - Completion loads error and status, clears busy and data request, pends interrupt
// - Interrupt line asserted only if pending, enable bit clear, and selected
// - Selected when host drive select bit equals jumper or cable device number
// - Abort completes with error status bit and abort error bit set
// - Non-data register transfers move one 8-bit value
// - Queued commands may release bus by clearing busy and data request early
// - Device loads byte count with bytes moved this data request
// - Signature in command registers shows packet feature support
// - Each Ultra DMA burst spans one acknowledge assertion and negation
// - Track accepted uncompleted queued commands; only queued commands may overlap
module adc_core #(
  parameter bit PACKET_DEV = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_cable_select_pin,
  input wire logic i_irq_disable_n,
  input wire logic i_udma_en,
  input wire logic i_dmack_n,
  input wire logic i_done,
  input wire logic i_abort,
  input wire logic [7:0] i_done_status,
  input wire logic [7:0] i_done_error,
  input wire logic i_release,
  input wire logic i_drq_set,
  input wire logic [15:0] i_xfer_bytes,
  input wire logic i_tagged_queuing,
  input wire logic [4:0] i_tag,
  output logic [7:0] o_rdata,
  output logic o_intrq,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic o_refused,
  output logic o_queue_any,
  output logic o_burst_start,
  output logic o_burst_end
);
  typedef enum logic [2:0] {
    ADC_IDLE = 3'b001,
    ADC_BUSY = 3'b010,
    ADC_PEND = 3'b100
  } adc_state_t;
  adc_state_t state_reg, state_next;
  logic [7:0] status_reg, error_reg, devreg_reg, cnt_reg, lba_reg;
  logic [15:0] bcnt_reg;
  logic [7:0] rdata_reg;
  logic intrq_reg, cmdv_reg, refused_reg, bs_reg, be_reg, dmack_reg, qany_reg;
  logic [7:0] cmd_reg;
  logic q_any, q_hit;

  wire selected = devreg_reg[adc_pkg::DEV_SEL_BIT] == i_cable_select_pin;
  wire busy = status_reg[adc_pkg::ST_BUSY];
  wire wr_cmd = i_wr && i_addr == adc_pkg::REG_COMMAND;
  wire accept_raw = wr_cmd && selected && !busy;
  // overlap only for queued commands on a free tag
  wire accept = accept_raw && (!q_any || (i_tagged_queuing && !q_hit));
  wire finish = (i_done || i_abort) && busy;
  // device grant clipped to host limit
  wire [15:0] grant = (i_xfer_bytes > bcnt_reg) ? bcnt_reg : i_xfer_bytes;
  wire dmack_fall = i_udma_en && dmack_reg && !i_dmack_n;
  wire dmack_rise = i_udma_en && !dmack_reg && i_dmack_n;

  adc_queue u_queue (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_set(accept && i_tagged_queuing),
    .i_set_tag(i_tag),
    .i_clear(finish && i_tagged_queuing),
    .i_clear_tag(i_tag),
    .o_any(q_any),
    .o_busy_tag(q_hit)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ADC_IDLE: if (accept) state_next = ADC_BUSY;
      ADC_BUSY: if (finish) state_next = ADC_PEND;
      // Pending cleared by a new command
      ADC_PEND: if (accept) state_next = ADC_BUSY;
      default: state_next = ADC_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ADC_IDLE;
      status_reg <= adc_pkg::STATUS_RST;
      error_reg <= adc_pkg::ERROR_RST;
      devreg_reg <= 8'h00;
      bcnt_reg <= 16'h0000;
      cnt_reg <= adc_pkg::SIG_COUNT;
      lba_reg <= adc_pkg::SIG_LBA;
      cmd_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (i_wr && i_addr == adc_pkg::REG_DEVICE) begin
        devreg_reg <= i_wdata;
      end
      if (i_wr && i_addr == adc_pkg::REG_SECCNT) begin
        cnt_reg <= i_wdata;
      end
      if (i_wr && i_addr == adc_pkg::REG_LBA_LO) begin
        lba_reg <= i_wdata;
      end
      if (i_wr && i_addr == adc_pkg::REG_BCNT_LO && !busy) begin
        bcnt_reg[7:0] <= i_wdata;
      end else if (i_wr && i_addr == adc_pkg::REG_BCNT_HI && !busy) begin
        bcnt_reg[15:8] <= i_wdata;
      // byte count for this data request
      end else if (i_drq_set && busy) begin
        bcnt_reg <= grant;
      end
      if (accept) begin
        cmd_reg <= i_wdata;
        status_reg <= 8'h80;
      end else if (finish) begin
        status_reg <= (i_done_status & 8'h77) | (i_abort ? 8'h01 : 8'h00);
        error_reg <= i_abort ? (i_done_error | 8'h04) : i_done_error;
      end else if (i_release && busy && i_tagged_queuing) begin
        status_reg[adc_pkg::ST_BUSY] <= 1'b0;
        status_reg[adc_pkg::ST_DRQ] <= 1'b0;
      end else if (i_drq_set && busy) begin
        status_reg[adc_pkg::ST_DRQ] <= 1'b1;
      end
    end
  end

  // signature on the byte count registers
  wire [7:0] sig_lo = PACKET_DEV ? adc_pkg::SIG_PKT_LO : adc_pkg::SIG_ATA_LO;
  wire [7:0] sig_hi = PACKET_DEV ? adc_pkg::SIG_PKT_HI : adc_pkg::SIG_ATA_HI;
  wire sig_shown = state_reg == ADC_IDLE && bcnt_reg == 16'h0000;
  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      adc_pkg::REG_ERROR: rd_mux = error_reg;
      adc_pkg::REG_SECCNT: rd_mux = cnt_reg;
      adc_pkg::REG_LBA_LO: rd_mux = lba_reg;
      adc_pkg::REG_BCNT_LO: rd_mux = sig_shown ? sig_lo : bcnt_reg[7:0];
      adc_pkg::REG_BCNT_HI: rd_mux = sig_shown ? sig_hi : bcnt_reg[15:8];
      adc_pkg::REG_DEVICE: rd_mux = devreg_reg;
      adc_pkg::REG_COMMAND: rd_mux = status_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  wire selected_next = ((i_wr && i_addr == adc_pkg::REG_DEVICE) ? i_wdata[adc_pkg::DEV_SEL_BIT]
                        : devreg_reg[adc_pkg::DEV_SEL_BIT]) == i_cable_select_pin;
  wire intrq_next = state_next == ADC_PEND && !i_irq_disable_n && selected_next;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= 8'h00;
      intrq_reg <= 1'b0;
      cmdv_reg <= 1'b0;
      refused_reg <= 1'b0;
      dmack_reg <= 1'b1;
      bs_reg <= 1'b0;
      be_reg <= 1'b0;
      qany_reg <= 1'b0;
    end else begin
      rdata_reg <= i_rd ? rd_mux : rdata_reg;
      intrq_reg <= intrq_next;
      cmdv_reg <= accept;
      refused_reg <= accept_raw && !accept;
      dmack_reg <= i_dmack_n;
      bs_reg <= dmack_fall;
      be_reg <= dmack_rise;
      // Queue flag lags one cycle so the output leaves a flop
      qany_reg <= q_any;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_intrq = intrq_reg;
  assign o_cmd_valid = cmdv_reg;
  assign o_cmd_code = cmd_reg;
  assign o_refused = refused_reg;
  assign o_queue_any = qany_reg;
  assign o_burst_start = bs_reg;
  assign o_burst_end = be_reg;

  accept_gate_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_cmd_valid |-> $past(wr_cmd) && !$past(busy) && $past(selected))
    else $error("command accepted while busy or unselected");
  sequence s_finish;
    finish;
  endsequence
  done_flags_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    s_finish |=> !status_reg[adc_pkg::ST_BUSY] && !status_reg[adc_pkg::ST_DRQ] && state_reg == ADC_PEND)
    else $error("completion did not clear busy or data request");
  irq_gate_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_intrq |-> state_reg == ADC_PEND && $past(!i_irq_disable_n))
    else $error("interrupt raised outside pending or while disabled");
  abort_bits_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_abort && finish |=> status_reg[adc_pkg::ST_ERR] && error_reg[adc_pkg::ER_ABORT])
    else $error("abort did not set error and abort bits");
  release_bus_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_release && busy && i_tagged_queuing && !finish && !accept |=> !busy && !status_reg[adc_pkg::ST_DRQ])
    else $error("bus release left busy or data request set");
  bcnt_limit_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_drq_set && busy && !(i_wr && i_addr[2:1] == 2'b10) |=> bcnt_reg <= $past(bcnt_reg))
    else $error("byte count exceeded host limit");
  burst_edge_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_dmack_n ##1 (i_udma_en && !i_dmack_n) |=> o_burst_start)
    else $error("burst start not flagged");
  queue_only_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    accept && q_any |-> i_tagged_queuing)
    else $error("non-queued command overlapped outstanding work");
endmodule
`default_nettype wire

// File: verification/adc_host_model.sv
// Host adapter model issuing register transfers
`default_nettype none
module adc_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    // Stale data never lingers on a released bus
    o_wdata <= ~d;
  endtask
  task automatic get(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule
`default_nettype wire

// File: verification/adc_core_test.sv
// Self-checking bench for the command and status core
`default_nettype none
module adc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic wr, rd;
  wire logic [2:0] addr;
  wire logic [7:0] wdata;
  logic irq_dis_n = 1'b0, udma = 1'b0, dmack_n = 1'b1, cable_select_pin = 1'b1;
  logic done = 1'b0, abort = 1'b0, rel = 1'b0, data_request_flag = 1'b0, tq = 1'b0;
  logic [4:0] tag = 5'h00;
  logic [7:0] rdata, code, d;
  logic intrq, cv, refd, qany, bs, be;
  int errors = 0, check_count = 0, nbs = 0, nbe = 0;
  always #20 clk = ~clk;
  adc_core uut (.i_clock(clk), .i_reset_n(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .i_cable_select_pin(cable_select_pin), .i_irq_disable_n(irq_dis_n), .i_udma_en(udma), .i_dmack_n(dmack_n),
    .i_done(done), .i_abort(abort), .i_done_status(8'hD8), .i_done_error(8'h00), .i_release(rel),
    .i_drq_set(data_request_flag), .i_xfer_bytes(16'h0200), .i_tagged_queuing(tq), .i_tag(tag), .o_rdata(rdata),
    .o_intrq(intrq), .o_cmd_valid(cv), .o_cmd_code(code), .o_refused(refd), .o_queue_any(qany),
    .o_burst_start(bs), .o_burst_end(be));
  adc_host_model host (.i_clock(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  always @(posedge clk) begin
    nbs += bs;
    nbe += be;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input string n, input logic [7:0] e);
    logic [7:0] v;
    host.get(a, v);
    chk(n, e, v);
  endtask
  // Engine pulses: done, abort, release, data request
  task automatic eng(input logic [3:0] m);
    @(posedge clk);
    {done, abort, rel, data_request_flag} <= m;
    @(posedge clk);
    {done, abort, rel, data_request_flag} <= 4'h0;
  endtask
  task automatic s_reset;
    rchk(adc_pkg::REG_ERROR, "error", adc_pkg::ERROR_RST);
    rchk(adc_pkg::REG_COMMAND, "status", adc_pkg::STATUS_RST);
    rchk(adc_pkg::REG_SECCNT, "count", adc_pkg::SIG_COUNT);
    rchk(adc_pkg::REG_LBA_LO, "lba", adc_pkg::SIG_LBA);
    rchk(adc_pkg::REG_BCNT_LO, "sig lo", adc_pkg::SIG_PKT_LO);
    rchk(adc_pkg::REG_BCNT_HI, "sig hi", adc_pkg::SIG_PKT_HI);
  endtask
  task automatic s_cmd;
    host.put(adc_pkg::REG_DEVICE, 8'h00);
    host.put(adc_pkg::REG_COMMAND, 8'hA0);
    #1 chk("unselected", 8'h00, {7'h00, cv});
    host.put(adc_pkg::REG_DEVICE, 8'h10);
    host.put(adc_pkg::REG_BCNT_LO, 8'h00);
    host.put(adc_pkg::REG_BCNT_HI, 8'h04);
    host.put(adc_pkg::REG_COMMAND, 8'hA0);
    #1 chk("accept", 8'h01, {7'h00, cv});
    chk("code", 8'hA0, code);
    rchk(adc_pkg::REG_COMMAND, "busy", 8'h80);
    host.put(adc_pkg::REG_COMMAND, 8'hEC);
    #1 chk("while busy", 8'h00, {7'h00, cv});
    eng(4'h1);
    host.get(adc_pkg::REG_COMMAND, d);
    chk("drq", 8'h01, {7'h00, d[adc_pkg::ST_DRQ]});
    rchk(adc_pkg::REG_BCNT_LO, "bytes lo", 8'h00);
    rchk(adc_pkg::REG_BCNT_HI, "bytes hi", 8'h02);
    // Two reads of the data register during the data request; status must hold
    repeat (2) host.get(adc_pkg::REG_DATA, d);
    rchk(adc_pkg::REG_COMMAND, "drq held", 8'h88);
    eng(4'h8);
    repeat (2) @(posedge clk);
    #1 chk("intrq", 8'h01, {7'h00, intrq});
    @(posedge clk) irq_dis_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("disabled", 8'h00, {7'h00, intrq});
    @(posedge clk) irq_dis_n <= 1'b0;
    host.put(adc_pkg::REG_DEVICE, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("deselected", 8'h00, {7'h00, intrq});
    host.put(adc_pkg::REG_DEVICE, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk("reselected", 8'h01, {7'h00, intrq});
    @(posedge clk) cable_select_pin <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pin deselect", 8'h00, {7'h00, intrq});
    @(posedge clk) cable_select_pin <= 1'b1;
    rchk(adc_pkg::REG_COMMAND, "done status", 8'h50);
    rchk(adc_pkg::REG_ERROR, "done error", 8'h00);
  endtask
  task automatic s_abort;
    // Host limit below the engine's 0x200 request, so the clip shows
    host.put(adc_pkg::REG_BCNT_HI, 8'h01);
    host.put(adc_pkg::REG_COMMAND, 8'hA0);
    eng(4'h1);
    rchk(adc_pkg::REG_BCNT_HI, "limit hi", 8'h01);
    rchk(adc_pkg::REG_BCNT_LO, "limit lo", 8'h00);
    eng(4'h4);
    host.get(adc_pkg::REG_COMMAND, d);
    chk("abort err", 8'h01, {7'h00, d[adc_pkg::ST_ERR]});
    chk("abort busy", 8'h00, {7'h00, d[adc_pkg::ST_BUSY]});
    host.get(adc_pkg::REG_ERROR, d);
    chk("abort bit", 8'h01, {7'h00, d[adc_pkg::ER_ABORT]});
  endtask
  task automatic s_queue;
    @(posedge clk) tq <= 1'b1;
    tag <= 5'h03;
    host.put(adc_pkg::REG_COMMAND, 8'hC7);
    #1 chk("queued", 8'h01, {7'h00, cv});
    eng(4'h2);
    host.get(adc_pkg::REG_COMMAND, d);
    chk("release", 8'h00, d & 8'h88);
    chk("queue any", 8'h01, {7'h00, qany});
    @(posedge clk) tag <= 5'h04;
    host.put(adc_pkg::REG_COMMAND, 8'hC7);
    #1 chk("second", 8'h01, {7'h00, cv});
    eng(4'h2);
    tq <= 1'b0;
    host.put(adc_pkg::REG_COMMAND, 8'hA0);
    #1 chk("refused", 8'h01, {7'h00, refd});
  endtask
  task automatic s_burst;
    @(posedge clk);
    udma <= 1'b1;
    dmack_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("starts", 8'h01, nbs[7:0]);
    dmack_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("ends", 8'h01, nbe[7:0]);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    s_reset;
    s_cmd;
    s_abort;
    s_queue;
    s_burst;
    summarize;
  end
  // Whole run needs under a thousand cycles
  initial begin
    #200000;
    errors++;
    summarize;
  end
endmodule
`default_nettype wire
